/* File: logic/beat_pulse_top.sv */
// Contract
// - Straps c=1 b=1 a=0 select standalone mode
// - Standalone: serial port unused, heart rate only
// - One 793 us pulse per heartbeat taken; beats during a pulse are dropped
// - No pulses outside standalone mode
// - Standalone starts in equipment ready state
module beat_pulse_top #(
  parameter int PULSE_CYCLES_P = beat_pulse_pkg::PULSE_CYCLES
) (
  // Clock, reset, enable
  input  wire logic                        clk_sys_in,
  input  wire logic                        reset_n_in,
  input  wire logic                        clk_en_in,
  // Rate straps
  input  wire logic                        rate_strap_a_in,
  input  wire logic                        rate_strap_b_in,
  input  wire logic                        rate_strap_c_in,
  // Heartbeat event from the radio side
  input  wire logic                        heartbeat_in,
  // Outputs
  output logic                             beat_pulse_out,
  output logic                             serial_port_en_out,
  output logic                             standalone_out,
  output beat_pulse_pkg::start_state_t     start_state_out
);
  import beat_pulse_pkg::*;

  // ==========================================================
  // State and wiring
  // ==========================================================
  beat_pulse_if bus ();
  logic       strap_taken_reg;
  logic       start_reg;
  logic [2:0] strap_pins;
  logic [2:0] strap_seen_reg;
  logic [7:0] beats_taken_reg;
  logic [7:0] pulses_begun_reg;
  logic       pulse_prev_reg;

  // ==========================================================
  // Parameter check
  // ==========================================================
  // The timer counts in CNT_W bits; a longer pulse would wrap it
  if (PULSE_CYCLES_P < 1 || PULSE_CYCLES_P >= (1 << CNT_W)) begin : g_bad_width
    $error("PULSE_CYCLES_P does not fit the width counter");
  end

  // ==========================================================
  // Strap decode
  // ==========================================================
  // Shared by the capture logic and the checks
  function automatic logic strap_is_standalone(input logic [2:0] straps);
    return straps == STANDALONE_STRAP;
  endfunction

  assign strap_pins = {rate_strap_c_in, rate_strap_b_in, rate_strap_a_in};

  // ==========================================================
  // Strap bits
  // ==========================================================
  // Each strap is kept on its own flop so the checks see what was decided on
  for (genvar i = 0; i < 3; i++) begin : g_strap
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
        strap_seen_reg[i] <= 1'b0;
      end else if (clk_en_in && !strap_taken_reg) begin
        strap_seen_reg[i] <= strap_pins[i];
      end
    end
  end

  // ==========================================================
  // Strap capture, once after reset release
  // ==========================================================
  // Straps are sampled on the first enabled edge so a strap change later cannot flip modes mid-session
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      strap_taken_reg    <= 1'b0;
      standalone_out     <= 1'b0;
      serial_port_en_out <= 1'b0;
      start_state_out    <= module_off_state;
    end else if (clk_en_in && !strap_taken_reg) begin
      strap_taken_reg <= 1'b1;
      if (strap_is_standalone(strap_pins)) begin
        standalone_out     <= 1'b1;
        serial_port_en_out <= 1'b0;
        start_state_out    <= equipment_ready_state;
      end else begin
        standalone_out     <= 1'b0;
        serial_port_en_out <= 1'b1;
        start_state_out    <= module_off_state;
      end
    end
  end

  // ==========================================================
  // Beat start request; beats during a pulse are dropped
  // ==========================================================
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      start_reg <= 1'b0;
    end else if (clk_en_in) begin
      start_reg <= heartbeat_in && standalone_out && !bus.busy && !start_reg;
    end
  end

  assign bus.start_pulse = start_reg;

  beat_pulse_timer #(.PULSE_CYCLES_P(PULSE_CYCLES_P)) u_timer (
    .clk_sys_in (clk_sys_in),
    .reset_n_in (reset_n_in),
    .enable_in  (clk_en_in),
    .tmr        (bus.timer),
    .pulse_out  (beat_pulse_out)
  );

  // ==========================================================
  // Tallies for the checks
  // ==========================================================
  // Wrapping 8-bit tallies of beats taken and pulses begun; only their difference matters
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      beats_taken_reg  <= 8'h00;
      pulses_begun_reg <= 8'h00;
      pulse_prev_reg   <= 1'b0;
    end else if (clk_en_in) begin
      pulse_prev_reg <= beat_pulse_out;
      if (heartbeat_in && standalone_out && !beat_pulse_out && !start_reg) begin
        beats_taken_reg <= beats_taken_reg + 8'h01;
      end
      if (beat_pulse_out && !pulse_prev_reg) begin
        pulses_begun_reg <= pulses_begun_reg + 8'h01;
      end
    end
  end

  // ==========================================================
  // Mode checks
  // ==========================================================
  // The mode is settled on the first enabled edge and then never moves
  quiet_offmode_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    !standalone_out |-> !beat_pulse_out)
    else $error("Pulse outside standalone");

  serial_off_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    standalone_out |-> !serial_port_en_out)
    else $error("Serial active in standalone");

  serial_on_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (strap_taken_reg && !standalone_out) |-> serial_port_en_out)
    else $error("Serial idle outside standalone");

  ready_start_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    standalone_out |-> start_state_out == equipment_ready_state)
    else $error("Wrong start state");

  off_start_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (strap_taken_reg && !standalone_out) |-> start_state_out == module_off_state)
    else $error("Wrong start state outside standalone");

  strap_decode_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (clk_en_in && !strap_taken_reg) |=> standalone_out == strap_is_standalone($past(strap_pins)))
    else $error("Strap decode wrong");

  strap_kept_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    strap_taken_reg |-> standalone_out == strap_is_standalone(strap_seen_reg))
    else $error("Mode differs from kept straps");

  mode_stable_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    strap_taken_reg |=> $stable(standalone_out) && $stable(start_state_out))
    else $error("Mode changed after capture");

  // ==========================================================
  // Pulse checks
  // ==========================================================
  // A beat that arrives while a pulse is out is dropped, never queued
  beat_to_pulse_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (clk_en_in && heartbeat_in && standalone_out && !beat_pulse_out && !start_reg)
      ##1 clk_en_in |=> beat_pulse_out)
    else $error("Beat produced no pulse");

  one_start_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    start_reg |-> !beat_pulse_out)
    else $error("Start request during pulse");

  rise_has_start_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    $rose(beat_pulse_out) |-> $past(start_reg))
    else $error("Pulse without a beat");

  no_start_off_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    !standalone_out |-> !start_reg)
    else $error("Start request outside standalone");

  tally_match_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    8'(beats_taken_reg - pulses_begun_reg) <= 8'h01)
    else $error("Beats and pulses out of step");

  // ==========================================================
  // Freeze checks
  // ==========================================================
  hold_freeze_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    !clk_en_in |=> $stable(beat_pulse_out))
    else $error("Output moved while frozen");

  start_freeze_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    !clk_en_in |=> $stable(start_reg))
    else $error("Start request moved while frozen");

  // ==========================================================
  // Cover points
  // ==========================================================
  pulse_seen_c: cover property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    $fell(beat_pulse_out));
  standalone_c: cover property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    $rose(standalone_out));
  serial_mode_c: cover property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    $rose(serial_port_en_out));
  frozen_pulse_c: cover property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    !clk_en_in && beat_pulse_out);
  beat_dropped_c: cover property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    heartbeat_in && beat_pulse_out);
endmodule // beat_pulse_top

/* File: logic/beat_pulse_pkg.sv */
package beat_pulse_pkg;
  // ==========================================================
  // Strap pattern and timing
  // ==========================================================
  localparam logic [2:0]  STANDALONE_STRAP = 3'h6;
  localparam int          CLK_FREQ_HZ      = 10000000;
  localparam int          PULSE_WIDTH_US   = 793;
  // Exact width: 793 us at 10 MHz is a whole number of cycles
  localparam int          PULSE_CYCLES     = (PULSE_WIDTH_US * (CLK_FREQ_HZ / 1000000));
  localparam int          CNT_W            = 14;
  localparam logic [CNT_W-1:0] CNT_ZERO    = 14'h0000;

  // ==========================================================
  // Start-up state chosen by the straps
  // ==========================================================
  typedef enum logic [1:0] {
    module_off_state      = 2'b00,
    equipment_ready_state = 2'b01
  } start_state_t;
endpackage

/* File: logic/beat_pulse_if.sv */
interface beat_pulse_if;
  import beat_pulse_pkg::*;
  logic start_pulse;
  logic busy;
  modport ctrl  (output start_pulse, input busy);
  modport timer (input start_pulse, output busy);
endinterface

/* File: logic/beat_pulse_timer.sv */
module beat_pulse_timer #(
  parameter int PULSE_CYCLES_P = beat_pulse_pkg::PULSE_CYCLES
) (
  // Clock, reset and enable
  input  wire logic  clk_sys_in,
  input  wire logic  reset_n_in,
  input  wire logic  enable_in,
  // Control
  beat_pulse_if.timer tmr,
  // Pin
  output logic       pulse_out
);
  import beat_pulse_pkg::*;

  // The counter has CNT_W bits; a longer pulse would wrap it
  if (PULSE_CYCLES_P < 1 || PULSE_CYCLES_P >= (1 << CNT_W)) begin : g_bad_cycles
    $error("PULSE_CYCLES_P out of range");
  end

  localparam logic [CNT_W-1:0] LAST      = CNT_W'(PULSE_CYCLES_P - 1);
  localparam logic [CNT_W:0]   SEEN_WANT = (CNT_W+1)'(PULSE_CYCLES_P);
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W:0]   seen_len_reg;

  // ==========================================================
  // Width counter
  // ==========================================================
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cnt_reg   <= CNT_ZERO;
      pulse_out <= 1'b0;
    end else if (enable_in) begin
      if (!pulse_out && tmr.start_pulse) begin
        pulse_out <= 1'b1;
        cnt_reg   <= CNT_ZERO;
      end else if (pulse_out) begin
        if (cnt_reg == LAST) begin
          pulse_out <= 1'b0;
        end else begin
          cnt_reg <= cnt_reg + 14'h0001;
        end
      end
    end
  end

  assign tmr.busy = pulse_out;

  // ==========================================================
  // Width check from a separate tally of enabled high cycles
  // ==========================================================
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      seen_len_reg <= '0;
    end else if (enable_in) begin
      seen_len_reg <= pulse_out ? seen_len_reg + 1'b1 : '0;
    end
  end

  width_count_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    $fell(pulse_out) |-> seen_len_reg == SEEN_WANT)
    else $error("Pulse width wrong");
endmodule // beat_pulse_timer

/* File: test/console_model.sv */
module console_model (
  input  wire logic clk_sys_in,
  input  wire logic pulse_in,
  output int        width_out,
  output int        interval_out,
  output int        count_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int   hi_cnt  = 0;
  int   gap_cnt = 0;
  logic prev    = 1'b0;
  initial begin
    width_out = 0;
    interval_out = 0;
    count_out = 0;
  end
  // Edge-to-edge cycle count; bpm is 60 over interval times 100 ns
  always @(posedge clk_sys_in) begin
    prev <= pulse_in;
    gap_cnt <= gap_cnt + 1;
    hi_cnt <= pulse_in ? hi_cnt + 1 : 0;
    if (pulse_in && !prev) begin
      interval_out <= gap_cnt;
      gap_cnt <= 1;
      count_out <= count_out + 1;
    end
    if (!pulse_in && prev) width_out <= hi_cnt;
  end
endmodule // console_model

/* File: test/standalone_heart_rate_pulse_tb_top.sv */
module standalone_heart_rate_pulse_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import beat_pulse_pkg::*;
  localparam int PW = 10;
  logic clk_sys_in, reset_n_in, clk_en_in, heartbeat_in, beat_pulse_out, serial_port_en_out, standalone_out;
  logic [2:0] strap;
  start_state_t start_state_out;
  int width, interval, count, err_count, n_compared, base, frz;
  int gaps[4];
  logic [31:0] lfsr = 32'hb45f64d7;
  beat_pulse_top #(.PULSE_CYCLES_P(PW)) i_beat_pulse_top (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
    .clk_en_in(clk_en_in), .rate_strap_a_in(strap[0]), .rate_strap_b_in(strap[1]), .rate_strap_c_in(strap[2]),
    .heartbeat_in(heartbeat_in), .beat_pulse_out(beat_pulse_out), .serial_port_en_out(serial_port_en_out),
    .standalone_out(standalone_out), .start_state_out(start_state_out));
  console_model i_console_model (.clk_sys_in(clk_sys_in), .pulse_in(beat_pulse_out),
    .width_out(width), .interval_out(interval), .count_out(count));
  initial begin
    clk_sys_in = 1'b0;
    forever #50 clk_sys_in = ~clk_sys_in;
  end
  function automatic int next_rand();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return int'(lfsr[7:0]);
  endfunction
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // One-cycle heartbeat, then idle until the next one is due
  task automatic beat(input int sp);
    heartbeat_in = 1'b1;
    @(posedge clk_sys_in) #10;
    heartbeat_in = 1'b0;
    repeat (sp - 1) @(posedge clk_sys_in);
    #10;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    err_count++;
    conclude();
  end
  initial begin
    heartbeat_in = 1'b0;
    reset_n_in = 1'b0;
    strap = 3'h0;
    clk_en_in = 1'b1;
    err_count = 0;
    n_compared = 0;
    for (int s = 0; s < 8; s++) begin
      reset_n_in = 1'b0;
      strap = s[2:0];
      repeat (6) @(posedge clk_sys_in);
      #10 reset_n_in = 1'b1;
      repeat (3) @(posedge clk_sys_in);
      #10;
      check("standalone", standalone_out, s == 6);
      check("serial_en", serial_port_en_out, s != 6);
      check("start_state", start_state_out, (s == 6) ? equipment_ready_state : module_off_state);
      base = count;
      for (int i = 0; i < 4; i++) begin
        gaps[i] = PW + 3 + next_rand() % 20;
        beat(gaps[i]);
      end
      // Second beat lands inside the pulse and must be dropped
      beat(4);
      beat(PW + 10);
      check("pulses", count - base, (s == 6) ? 5 : 0);
      if (s == 6) begin
        check("width", width, PW);
        check("interval", interval, gaps[3]);
        // Freeze the enable mid-pulse: the pulse stretches by the frozen cycles
        base = count;
        frz = 1 + next_rand() % 8;
        beat(3);
        clk_en_in = 1'b0;
        repeat (frz) @(posedge clk_sys_in);
        #10;
        check("frozen_level", beat_pulse_out, 1'b1);
        clk_en_in = 1'b1;
        repeat (PW + 4) @(posedge clk_sys_in);
        #10;
        check("frozen_pulses", count - base, 1);
        check("frozen_width", width, PW + frz);
      end
    end
    conclude();
  end
endmodule // standalone_heart_rate_pulse_tb_top
